// file: hdl/wdu_pkg.sv
`default_nettype none
package wdu_pkg;
    // Memory address of the restart register
    localparam logic [15:0] WDU_RESTART_ADDR = 16'hff99;
    // Only write value that restarts the counter
    localparam logic [7:0] WDU_RESTART_KEY = 8'hac;
    // Fixed read values, chosen by the power-up option
    localparam logic [7:0] WDU_RESET_VAL_ON = 8'h9a;
    localparam logic [7:0] WDU_RESET_VAL_OFF = 8'h1a;
    // Reset-source flag register layout
    localparam logic [7:0] WDU_FLAGS_RESET = 8'h00;
    localparam int WDU_FLAG_WDT_BIT = 4;
    // Overflow period in system-clock cycles counted while the source clock runs, and counter width
    localparam int WDU_CNT_W = 16;
    localparam logic [15:0] WDU_OVF_CYCLES = 16'h1000;
endpackage : wdu_pkg
`default_nettype wire

// file: hdl/wdu_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module wdu_sync3 (
    input wire logic clk,     // System clock
    input wire logic nrst,    // Async reset, active low
    input wire logic clk_en,  // Freezes state when low
    input wire logic din,     // Asynchronous level
    output logic dout         // Filtered synchronous level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } wdu_sync_type;

    wdu_sync_type st;
    wdu_sync_type next_st;

    ////////////////////////////////////////////////////////////////
    // First stage feeds only the second; output moves when 2 and 3 agree
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.s1 = din;
            next_st.s2 = st.s1;
            next_st.s3 = st.s2;
            if (st.s2 == st.s3) begin
                next_st.out = st.s3;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.out;
endmodule : wdu_sync3
`default_nettype wire

// file: hdl/wdu_watchdog.sv
//Function
//- Key write clears counter, restarts counting
//- Reset value 1AH or 9AH by option
//- Non-key write forces internal reset
//- Reset deferred while source clock stopped
//- Single-bit access forces internal reset
//- Reads return fixed value, never key
//- Watchdog reset sets its source flag
//- Power-on clear zeroes flag register
`timescale 1ns/1ps
`default_nettype none
module wdu_watchdog #(
    parameter logic [15:0] OVF_CYCLES = wdu_pkg::WDU_OVF_CYCLES
) (
    input wire logic clk,                              // 250 MHz system clock
    input wire logic nrst,                             // Async system reset, low
    input wire logic npoc,                             // Power-on clear, async low
    input wire logic clk_en,                           // Freezes all state when low
    input wire logic watchdog_power_up_enable_option,  // Strap, stable during reset
    input wire logic src_clk_running,                  // Source clock active, async
    input wire logic [15:0] mem_addr,                  // CPU memory address
    input wire logic mem_wr,                           // Byte write strobe
    input wire logic mem_rd,                           // Byte read strobe
    input wire logic mem_bit_op,                       // Single-bit manipulation access
    input wire logic [7:0] mem_wdata,                  // Write data
    output logic [7:0] mem_rdata,                      // Registered read data
    output logic internal_reset_req,                   // One-cycle reset request
    output logic [7:0] reset_source_flag_register      // Reset-source flags
);
    typedef struct packed {
        logic loaded;
        logic enable;
        logic [wdu_pkg::WDU_CNT_W-1:0] count;
        logic pending;
        logic rst_req;
        logic [7:0] rdata;
    } wdu_state_type;

    wdu_state_type st;
    wdu_state_type next_st;
    logic [7:0] flags;
    logic src_run;
    logic hit;
    logic key_ok;
    logic bad_access;
    logic [7:0] fixed_val;
    logic overflow;

    ////////////////////////////////////////////////////////////////
    // Source clock status crosses in through a filtered synchroniser
    wdu_sync3 u_src_sync (
        .clk(clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .din(src_clk_running),
        .dout(src_run)
    );

    ////////////////////////////////////////////////////////////////
    // Access decode
    // A bit access is illegal even when it carries the key value
    // Reads with no bit flag are harmless and never arm a reset
    assign hit = (mem_addr == wdu_pkg::WDU_RESTART_ADDR);
    assign key_ok = hit && mem_wr && !mem_bit_op && (mem_wdata == wdu_pkg::WDU_RESTART_KEY);
    assign bad_access = hit && (mem_bit_op || (mem_wr && (mem_wdata != wdu_pkg::WDU_RESTART_KEY)));
    assign fixed_val = st.enable ? wdu_pkg::WDU_RESET_VAL_ON : wdu_pkg::WDU_RESET_VAL_OFF;
    assign overflow = st.enable && src_run && (st.count == OVF_CYCLES - 16'h0001);

    ////////////////////////////////////////////////////////////////
    // Next-state logic; counter only advances while the source clock runs
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.rst_req = 1'b0;
            // Strap caught on the first enabled cycle after release
            if (!st.loaded) begin
                next_st.loaded = 1'b1;
                next_st.enable = watchdog_power_up_enable_option;
            end
            if (key_ok && !st.pending) begin
                next_st.count = '0;
            end else if (st.enable && src_run && !st.pending) begin
                next_st.count = st.count + 16'h0001;
            end
            if (bad_access || (overflow && !key_ok)) begin
                next_st.pending = 1'b1;
            end
            // Held until the source clock is seen running again
            // Firing wins over a fresh arm in the same cycle; one reset covers both
            if (st.pending && src_run) begin
                next_st.rst_req = 1'b1;
                next_st.pending = 1'b0;
                next_st.count = '0;
            end
            // Reads never echo the key
            next_st.rdata = (hit && mem_rd) ? fixed_val : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Flag register survives system reset; only power-on clear zeroes it
    // Software reads it after restart to tell a watchdog reset from others
    always_ff @(posedge clk or negedge npoc) begin
        if (!npoc) begin
            flags <= wdu_pkg::WDU_FLAGS_RESET;
        end else if (clk_en && st.rst_req) begin
            flags[wdu_pkg::WDU_FLAG_WDT_BIT] <= 1'b1;
        end
    end

    assign mem_rdata = st.rdata;
    assign internal_reset_req = st.rst_req;
    assign reset_source_flag_register = flags;

    ////////////////////////////////////////////////////////////////
    // Checks
    AST_KEY_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && key_ok && !st.pending && !(st.pending && src_run)) |=> (st.count == '0))
        else $error("key write did not clear counter");

    AST_STRAP_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && !st.loaded) |=> (st.loaded && st.enable == $past(watchdog_power_up_enable_option)))
        else $error("power-up option not captured");

    AST_BAD_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && hit && mem_wr && !mem_bit_op && mem_wdata != wdu_pkg::WDU_RESTART_KEY)
        |=> st.pending)
        else $error("illegal write did not arm reset");

    AST_DEFER: assert property (@(posedge clk) disable iff (!nrst)
        (st.pending && !src_run) |=> !st.rst_req)
        else $error("reset fired with source clock stopped");

    AST_FIRE: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.pending && src_run) |=> (st.rst_req && !st.pending))
        else $error("pending reset not issued");

    AST_BIT_OP: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && hit && mem_bit_op) |=> st.pending)
        else $error("bit access did not arm reset");

    AST_READ_FIXED: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.loaded && hit && mem_rd) |=>
        (mem_rdata == ($past(st.enable) ? wdu_pkg::WDU_RESET_VAL_ON : wdu_pkg::WDU_RESET_VAL_OFF)))
        else $error("read value wrong");

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!npoc)
        (clk_en && st.rst_req) |=> flags[wdu_pkg::WDU_FLAG_WDT_BIT])
        else $error("watchdog flag not set");

    AST_POC_CLEAR: assert property (@(posedge clk)
        !npoc |-> (flags == 8'h00))
        else $error("power-on clear left flags set");

    AST_OVERFLOW: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && overflow && !key_ok && !st.pending) |=> st.pending ##1 st.rst_req)
        else $error("overflow did not cause reset");

    ////////////////////////////////////////////////////////////////
    // Side effects and quiet paths

    // One event per request, so the system never sees a doubled reset
    AST_REQ_PULSE: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.rst_req) |=> !st.rst_req)
        else $error("reset request longer than one cycle");

    // A request only ever follows an armed pending reset
    AST_REQ_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st.rst_req) |-> $past(st.pending))
        else $error("reset request without a cause");

    // Counter frozen while a deferred reset waits for the source clock
    AST_HOLD_COUNT: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.pending && !src_run) |=> $stable(st.count))
        else $error("counter moved while reset deferred");

    // Counter cannot advance with the source clock stopped
    AST_STOPPED_COUNT: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && !src_run && !st.pending && !key_ok) |=> $stable(st.count))
        else $error("counter moved with source clock stopped");

    // With counting disabled the counter never leaves zero
    AST_OFF_QUIET: assert property (@(posedge clk) disable iff (!nrst)
        (st.loaded && !st.enable) |-> (st.count == '0))
        else $error("counter ran while counting disabled");

    // No read strobe, no data: the bus sees zero otherwise
    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && !(hit && mem_rd)) |=> (mem_rdata == 8'h00))
        else $error("read data without a read");

    // The watchdog flag is sticky across system resets
    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!npoc)
        (clk_en && flags[wdu_pkg::WDU_FLAG_WDT_BIT]) |=> flags[wdu_pkg::WDU_FLAG_WDT_BIT])
        else $error("watchdog flag lost");

    // Accesses to other addresses never arm a reset
    AST_OTHER_ADDR: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && !hit && !st.pending && !overflow) |=> !st.pending)
        else $error("foreign access armed a reset");

    // The key itself never arms a reset
    AST_KEY_NO_RESET: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && key_ok && !st.pending && !overflow) |=> !st.pending)
        else $error("key write armed a reset");
endmodule : wdu_watchdog
`default_nettype wire

// file: verif/watchdog_restart_and_reset_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_restart_and_reset_tb_top;
    logic clk, nrst, npoc, clk_en, opt, src_run, mem_wr, mem_rd, mem_bit_op;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, flags;
    logic internal_reset_req;
    int err_total = 0;
    int checked = 0;
    int nreq = 0;
    logic [15:0] t_addr [3] = '{16'hff99, 16'hff99, 16'h0000};
    logic [7:0] t_data [3] = '{8'h55, 8'hac, 8'h55};
    logic t_bit [3] = '{1'b0, 1'b1, 1'b0};
    int t_exp [3] = '{1, 1, 0};
    wdu_watchdog #(.OVF_CYCLES(16'h0010)) dut (.clk(clk), .nrst(nrst), .npoc(npoc),
        .clk_en(clk_en), .watchdog_power_up_enable_option(opt), .src_clk_running(src_run),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_bit_op(mem_bit_op),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .internal_reset_req(internal_reset_req),
        .reset_source_flag_register(flags));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a pulse counter sampled before each edge settles
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (internal_reset_req === 1'b1) nreq++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task rst(input logic o);
        @(posedge clk);
        nrst <= 1'b0;
        opt <= o;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1;
    endtask : rst
    // Held until the taking edge, then released
    task wr(input logic [15:0] a, input logic [7:0] d, input logic b);
        @(posedge clk);
        mem_addr <= a;
        mem_wdata <= d;
        mem_wr <= 1'b1;
        mem_bit_op <= b;
        @(posedge clk);
        mem_wr <= 1'b0;
        mem_bit_op <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        mem_addr <= a;
        mem_rd <= 1'b1;
        @(posedge clk);
        mem_rd <= 1'b0;
        #1;
        check(mem_rdata, exp);
    endtask : rd
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #20000;
        err_total++;
        conclude();
    end
    initial begin
        {nrst, clk_en, src_run, npoc, opt} = 5'b01111;
        {mem_wr, mem_rd, mem_bit_op, mem_addr, mem_wdata} = '0;
        rst(1'b1);
        rd(16'hff99, 8'h9a);
        wr(16'hff99, 8'hac, 1'b0);
        rd(16'hff99, 8'h9a);
        rd(16'h0000, 8'h00);
        $display("test read done");
        // Restarts every ten cycles stay inside a sixteen-cycle period
        nreq = 0;
        repeat (6) begin
            wr(16'hff99, 8'hac, 1'b0);
            idle(8);
        end
        check(8'(nreq), 8'h00);
        idle(24);
        check(8'(nreq), 8'h01);
        check(flags, 8'h10);
        rst(1'b1);
        check(flags, 8'h10);
        $display("test overflow done");
        // Bad key, bit access with the key, bad key elsewhere
        for (int i = 0; i < 3; i++) begin
            nreq = 0;
            wr(t_addr[i], t_data[i], t_bit[i]);
            idle(4);
            check(8'(nreq), 8'(t_exp[i]));
            rst(1'b1);
        end
        $display("test illegal done");
        src_run <= 1'b0;
        idle(6);
        nreq = 0;
        wr(16'hff99, 8'h55, 1'b0);
        idle(20);
        check(8'(nreq), 8'h00);
        src_run <= 1'b1;
        idle(8);
        check(8'(nreq), 8'h01);
        rst(1'b1);
        $display("test deferral done");
        npoc <= 1'b0;
        idle(1);
        npoc <= 1'b1;
        idle(1);
        check(flags, 8'h00);
        rst(1'b0);
        rd(16'hff99, 8'h1a);
        nreq = 0;
        idle(40);
        check(8'(nreq), 8'h00);
        $display("test option off done");
        conclude();
    end
endmodule : watchdog_restart_and_reset_tb_top
`default_nettype wire
